// ---- hdl/ewp_write_pulse.sv ----
`timescale 1ns/1ns
module ewp_write_pulse #(
  parameter int unsigned FAST_CYCLES = ewp_pkg::FAST_CYC,
  parameter int unsigned SLOW_CYCLES = ewp_pkg::SLOW_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ewp_pkg::ewp_req_s req,
  input wire logic slow_part,
  output ewp_pkg::ewp_stat_s stat
);
  import ewp_pkg::*;

  // a write is select and strobe together, both taken as plain levels
  function automatic logic is_write(input ewp_req_s r);
    return r.sel && r.wr;
  endfunction

  // pulse length for the fitted part; the cast cuts it to the counter width
  function automatic logic [CNT_W-1:0] pulse_len(input logic slow);
    logic [CNT_W-1:0] len;
    if (slow) begin
      len = CNT_W'(SLOW_CYCLES);
    end else begin
      len = CNT_W'(FAST_CYCLES);
    end
    return len;
  endfunction

  ewp_state_e state;
  logic wr_req;
  logic start;
  logic expired;
  logic [CNT_W-1:0] next_len;
  logic [CNT_W-1:0] len_hold;
  logic [CNT_W-1:0] busy_cyc;

  assign wr_req = is_write(req);
  // a write seen while busy is dropped, not queued
  assign start = (state == EWP_IDLE) && wr_req;
  // slow_part only matters on the start edge; later changes are ignored
  assign next_len = pulse_len(slow_part);

  // the one-shot is the only timebase and counts ce-high cycles only
  ewp_timer #(
    .CNT_W(CNT_W)
  ) ewp_timer_inst (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .load(start),
    .load_val(next_len),
    .expired(expired)
  );

  // done holds off a retrigger until the strobe drops: the strobe is a level
  // and would otherwise fire a second pulse straight after the first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= EWP_IDLE;
    end else if (ce) begin
      case (state)
        EWP_IDLE: begin
          if (start) begin
            state <= EWP_PULSE;
          end
        end
        EWP_PULSE: begin
          if (expired) begin
            state <= EWP_DONE;
          end
        end
        EWP_DONE: begin
          if (!wr_req) begin
            state <= EWP_IDLE;
          end
        end
        default: begin
          state <= EWP_IDLE;
        end
      endcase
    end
  end

  // busy and the shaper drive share one register pair so they cannot skew
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat <= '0;
    end else if (ce) begin
      if (start) begin
        stat <= '{busy: 1'b1, prog_pulse: 1'b1};
      end else if (state == EWP_PULSE && expired) begin
        stat <= '0;
      end
    end
  end

  // checking aids only: length chosen at start and ce-high cycles spent busy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      len_hold <= '0;
    end else if (ce && start) begin
      len_hold <= next_len;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_cyc <= '0;
    end else if (ce) begin
      if (start) begin
        busy_cyc <= '0;
      end else if (stat.busy) begin
        busy_cyc <= busy_cyc + 1'b1;
      end
    end
  end

  property p_start;
    @(posedge clk) disable iff (!rst_b)
      ce && start |=> stat.busy && stat.prog_pulse;
  endproperty
  a_start: assert property (p_start) else $error("write did not start pulse");

  property p_busy_eq;
    @(posedge clk) disable iff (!rst_b)
      stat.busy == stat.prog_pulse;
  endproperty
  a_busy_eq: assert property (p_busy_eq) else $error("busy differs from pulse");

  property p_no_start;
    @(posedge clk) disable iff (!rst_b)
      !wr_req && state == EWP_IDLE |=> !stat.busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("pulse without select and write");

  property p_ignore;
    @(posedge clk) disable iff (!rst_b)
      stat.busy && !expired |=> stat.busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy dropped early");

  property p_end;
    @(posedge clk) disable iff (!rst_b)
      ce && state == EWP_PULSE && expired |=> !stat.busy;
  endproperty
  a_end: assert property (p_end) else $error("busy held after expiry");

  // the pulse must last exactly the selected number of ce-high cycles
  property p_len;
    @(posedge clk) disable iff (!rst_b)
      ce && state == EWP_PULSE && expired |-> busy_cyc == len_hold - 1'b1;
  endproperty
  a_len: assert property (p_len) else $error("pulse length differs from part");

  property p_len_slow;
    @(posedge clk) disable iff (!rst_b)
      ce && start && slow_part |=> len_hold == CNT_W'(SLOW_CYCLES);
  endproperty
  a_len_slow: assert property (p_len_slow) else $error("slow part got wrong length");

  property p_len_fast;
    @(posedge clk) disable iff (!rst_b)
      ce && start && !slow_part |=> len_hold == CNT_W'(FAST_CYCLES);
  endproperty
  a_len_fast: assert property (p_len_fast) else $error("fast part got wrong length");

  // with ce low nothing may move, pulse and busy included
  property p_ce_hold;
    @(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(stat) && $stable(state);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved while ce low");

  property p_pulse_busy;
    @(posedge clk) disable iff (!rst_b)
      state == EWP_PULSE |-> stat.busy;
  endproperty
  a_pulse_busy: assert property (p_pulse_busy) else $error("busy low during pulse");

  property p_idle_quiet;
    @(posedge clk) disable iff (!rst_b)
      state == EWP_IDLE |-> !stat.busy;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("busy high while idle");

  property p_expire;
    @(posedge clk) disable iff (!rst_b)
      ce && state == EWP_PULSE && expired |=> state == EWP_DONE;
  endproperty
  a_expire: assert property (p_expire) else $error("pulse did not end at expiry");

  property p_done;
    @(posedge clk) disable iff (!rst_b)
      state == EWP_DONE |-> !stat.busy;
  endproperty
  a_done: assert property (p_done) else $error("busy high after expiry");

  // a strobe still held after expiry must not start a second pulse
  property p_done_hold;
    @(posedge clk) disable iff (!rst_b)
      ce && state == EWP_DONE && wr_req |=> state == EWP_DONE && !stat.busy;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("held strobe retriggered");

  property p_rearm;
    @(posedge clk) disable iff (!rst_b)
      ce && state == EWP_DONE && !wr_req |=> state == EWP_IDLE;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no rearm after strobe release");

  c_start: cover property (@(posedge clk) start);
  c_end: cover property (@(posedge clk) $fell(stat.busy));
  c_busy_wr: cover property (@(posedge clk) stat.busy && wr_req);
  c_slow: cover property (@(posedge clk) start && slow_part);
  c_ce_freeze: cover property (@(posedge clk) stat.busy && !ce);
endmodule

// ---- hdl/ewp_pkg.sv ----
// Functional notes
// - start only when select and write both active
// - pulse width 10ms fast, 50ms slow variant
// - busy asserted for the whole pulse
// - pulse drives the high-voltage wave shaper
package ewp_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PULSE_FAST_MS = 10;
  localparam int unsigned PULSE_SLOW_MS = 50;
  localparam int unsigned FAST_CYC = CLK_HZ / 1000 * PULSE_FAST_MS;
  localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * PULSE_SLOW_MS;
  localparam int CNT_W = 23;

  typedef enum logic [1:0] {
    EWP_IDLE = 2'b00,
    EWP_PULSE = 2'b01,
    EWP_DONE = 2'b11
  } ewp_state_e;

  typedef struct packed {
    logic sel;
    logic wr;
  } ewp_req_s;

  typedef struct packed {
    logic busy;
    logic prog_pulse;
  } ewp_stat_s;
endpackage

// ---- hdl/ewp_timer.sv ----
`timescale 1ns/1ns
module ewp_timer #(
  parameter int CNT_W = ewp_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic expired
);
  import ewp_pkg::*;
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (ce) begin
      if (load) begin
        cnt <= load_val;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  // one-cycle early so the pulse spans exactly load_val cycles
  assign expired = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// ---- tb/ewp_host.sv ----
`timescale 1ns/1ns
module ewp_host (
  input wire logic go,
  input wire logic [1:0] mode,
  output ewp_pkg::ewp_req_s req
);
  assign req.sel = go & mode[1];
  assign req.wr = go & mode[0];
endmodule

// ---- tb/ewp_write_pulse_tb.sv ----
`timescale 1ns/1ns
module ewp_write_pulse_tb;
  import ewp_pkg::*;
  localparam int FAST_T = 5;
  localparam int SLOW_T = 9;
  localparam int LIMIT = 40;
  logic clk = 0;
  logic rst_b = 0;
  logic go = 0;
  logic ce = 1;
  logic slow = 0;
  logic [1:0] mode = 2'h3;
  ewp_req_s req;
  ewp_stat_s stat;
  int fails = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  ewp_host ewp_host_inst (.go(go), .mode(mode), .req(req));
  ewp_write_pulse #(.FAST_CYCLES(FAST_T), .SLOW_CYCLES(SLOW_T)) ewp_write_pulse_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .req(req), .slow_part(slow), .stat(stat));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // counts busy cycles from the current negedge on; the bound stops a hang
  task automatic count_busy(output int k);
    k = 0;
    while (stat.busy === 1'b1 && k < LIMIT) begin
      check(stat.prog_pulse, 1);
      k++;
      @(negedge clk);
    end
    if (k == LIMIT) begin
      fails++;
      $display("[FAIL] %0t busy never dropped", $time);
    end
  endtask
  // strobe is kept up past expiry so a level retrigger would show
  task automatic write_pulse(input logic s, input int n);
    int k;
    @(negedge clk);
    slow = s;
    go = 1;
    @(negedge clk);
    count_busy(k);
    check(8'(k), 8'(n));
    repeat (3) begin
      @(negedge clk);
      check(stat, 0);
    end
    go = 0;
  endtask
  task automatic no_start(input logic [1:0] m);
    @(negedge clk);
    mode = m;
    go = 1;
    repeat (4) begin
      @(negedge clk);
      check(stat, 0);
    end
    go = 0;
    mode = 2'h3;
  endtask
  // the strobe drops and comes back mid-pulse; that second write is ignored
  task automatic retrigger;
    int k;
    @(negedge clk);
    slow = 0;
    go = 1;
    @(negedge clk);
    check(stat.busy, 1);
    @(negedge clk);
    go = 0;
    @(negedge clk);
    go = 1;
    @(negedge clk);
    count_busy(k);
    check(8'(k + 3), 8'(FAST_T));
    repeat (2) begin
      @(negedge clk);
      check(stat, 0);
    end
    go = 0;
  endtask
  // ce low for three cycles mid-pulse stretches the pulse by three cycles
  task automatic ce_freeze;
    int k;
    @(negedge clk);
    slow = 1;
    go = 1;
    @(negedge clk);
    ce = 0;
    repeat (3) begin
      @(negedge clk);
      check(stat, 2'h3);
    end
    ce = 1;
    count_busy(k);
    check(8'(k + 3), 8'(SLOW_T + 3));
    go = 0;
  endtask
  // a reset in mid-pulse drops busy and leaves the block ready for a write
  task automatic mid_reset;
    @(negedge clk);
    slow = 0;
    go = 1;
    repeat (2) @(negedge clk);
    check(stat.busy, 1);
    rst_b = 0;
    go = 0;
    @(negedge clk);
    check(stat, 0);
    @(negedge clk);
    rst_b = 1;
    @(negedge clk);
    check(stat, 0);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    check(stat, 0);
    rst_b = 1;
    write_pulse(0, FAST_T);
    write_pulse(1, SLOW_T);
    no_start(2'h2);
    no_start(2'h1);
    no_start(2'h0);
    retrigger();
    ce_freeze();
    mid_reset();
    write_pulse(0, FAST_T);
    summarize();
  end
endmodule
